/* File: common/sci_pkg.sv */
// Constants, register map and carrier types of the serial transceiver
package sci_pkg;
	// Register indices on the plain register port
	localparam logic [2:0] ADDR_CTRL_A = 3'h0;
	localparam logic [2:0] ADDR_CTRL_B = 3'h1;
	localparam logic [2:0] ADDR_CTRL_C = 3'h2;
	localparam logic [2:0] ADDR_STATUS_A = 3'h3;
	localparam logic [2:0] ADDR_DATA = 3'h4;
	localparam logic [2:0] ADDR_BAUD = 3'h5;
	// serial_ctrl_a fields
	localparam int A_LOOP = 7;
	localparam int A_EN = 6;
	localparam int A_TX_POLARITY_FLIP = 5;
	localparam int A_LONG = 4;
	localparam int A_WAKE = 3;
	localparam int A_IDLE_COUNT_START_SEL = 2;
	localparam int A_PEN = 1;
	localparam int A_PTY = 0;
	// serial_ctrl_b fields
	localparam int B_TIE = 7;
	localparam int B_TX_DONE_IRQ_EN = 6;
	localparam int B_RIE = 5;
	localparam int B_ILIE = 4;
	localparam int B_TE = 3;
	localparam int B_RE = 2;
	localparam int B_RWU = 1;
	localparam int B_SBK = 0;
	// serial_ctrl_c fields
	localparam int C_R8 = 7;
	localparam int C_T8 = 6;
	localparam int C_OVERRUN_IRQ_EN = 3;
	localparam int C_NOISE_IRQ_EN = 2;
	localparam int C_FRAMING_IRQ_EN = 1;
	localparam int C_PARITY_IRQ_EN = 0;
	// Values after reset
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'hc0;
	localparam logic [7:0] BAUD_RESET = 8'h00;
	// Bit timing in RT ticks, sixteen per bit
	localparam logic [3:0] RT_SAMPLE_A = 4'h7;
	localparam logic [3:0] RT_SAMPLE_B = 4'h8;
	localparam logic [3:0] RT_SAMPLE_C = 4'h9;
	localparam logic [3:0] RT_LAST = 4'hf;
	// Data bits per character and bits per idle character
	localparam logic [3:0] DATA_SHORT = 4'h8;
	localparam logic [3:0] DATA_LONG = 4'h9;
	localparam logic [3:0] IDLE_SHORT = 4'ha;
	localparam logic [3:0] IDLE_LONG = 4'hb;

	typedef struct packed {
		logic tx_empty;
		logic tx_done;
		logic rx_full;
		logic idle;
		logic overrun;
		logic noise;
		logic framing;
		logic parity;
	} status_type;

	typedef enum logic [1:0] {
		LINE_IDLE = 2'b00,
		LINE_START = 2'b01,
		LINE_DATA = 2'b10,
		LINE_STOP = 2'b11
	} line_state_type;

	// Parity over the 8 or 9 data bits of a character
	function automatic logic parity_of(input logic [8:0] v,
		input logic long_char);
		parity_of = long_char ? ^v : ^v[7:0];
	endfunction
endpackage

/* File: rtl/sci_core.sv */
// Asynchronous serial transceiver with error flags and register port
// What this block does
// - Overrun: keep old received character, drop the new one, set flag.
// - Noise flag set when any sampled bit of a character disagrees.
// - Framing flag set when the stop bit samples as 0.
// - Parity flag set when received parity mismatches configured parity.
// - Each error flag drives error interrupt only under its own enable.
// - Block keeps running in wait mode; enabled requests wake the CPU.
// - Stop mode halts the block; registers keep their values, the baud counter clears.
// - Debug break without permission: accesses never change status bits.
// - Debug break with permission: status bits clear and stay cleared.
// - Enabled block forces transmit pin output, receive pin input.
// - Loopback feeds transmitter into receiver, pin disconnected.
// - Unit enable gates block and baud; clearing sets tx flags.
// - Output inversion flips every transmitted level, idle included.
// - Length select gives 10 or 11 bit characters; parity takes top bit.
// - Wake select: 1 address mark wakes standby; 0 wakes only on a false start after an all-ones character, with idle count select clear.
// - Idle counting never advances when set; if clear it counts 1s from after start through the stop bit, never in idle.
// - Parity generated and checked in top bit, odd when select is 1.
// - Transmit enables gate empty and done flags onto transmit request.
// - Reset clears all control bits: 8 bit, no parity, disabled.
// - Framing flag rises with receive-full; breaks raise it too.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module sci_core
	import sci_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// System mode inputs
	input wire logic stop_mode,
	input wire logic debug_break,
	input wire logic break_clear_allow,
	// Port pins shared with the transceiver
	input wire logic port_dir_tx,
	input wire logic port_dir_rx,
	input wire logic port_out_tx,
	input wire logic rx_pin,
	output logic tx_pin,
	output logic tx_pin_oe,
	output logic rx_pin_oe,
	// Interrupt requests
	output logic err_irq,
	output logic tx_irq,
	output logic rx_irq,
	output logic cpu_wake
);

	logic [7:0] serial_ctrl_a;
	logic [7:0] serial_ctrl_b;
	logic [7:0] serial_ctrl_c;
	logic [7:0] baud_div;
	status_type serial_status_a;
	logic [7:0] serial_data_reg;
	logic [7:0] tx_hold;
	logic arm_rx;
	logic arm_tx;
	logic [7:0] baud_cnt;
	logic rt_tick;
	logic run;
	logic en;
	logic long_char;
	logic protect;
	logic clear_rx;
	logic clear_tx;
	// Transmitter
	line_state_type tx_state;
	logic [3:0] tx_rt;
	logic [3:0] tx_bit;
	logic [8:0] tx_shift;
	logic tx_line;
	logic tx_load;
	// Receiver
	line_state_type rx_state;
	logic [3:0] rx_rt;
	logic [3:0] rx_bit;
	logic [8:0] rx_shift;
	logic [1:0] rx_samp;
	logic rx_noise;
	logic rx_src;
	logic vote;
	logic unanimous;
	logic rx_done;
	logic [8:0] rx_char;
	logic rx_msb;
	logic [3:0] idle_cnt;
	logic idle_seen;
	logic idle_armed;

	assign en = serial_ctrl_a[A_EN];
	assign long_char = serial_ctrl_a[A_LONG];
	assign run = en && !stop_mode;
	assign protect = debug_break && !break_clear_allow;

	// Baud divider, one RT tick per divisor+1 clocks
	always_ff @(posedge ref_clk) begin
		if (reset || !run) begin
			baud_cnt <= 8'h00;
		end else if (baud_cnt == baud_div) begin
			baud_cnt <= 8'h00;
		end else begin
			baud_cnt <= baud_cnt + 8'h01;
		end
	end
	assign rt_tick = run && (baud_cnt == baud_div);

	// Pin ownership and loopback
	assign tx_pin = en ? (tx_line ^ serial_ctrl_a[A_TX_POLARITY_FLIP]) : port_out_tx;
	assign tx_pin_oe = en ? 1'b1 : port_dir_tx;
	assign rx_pin_oe = en ? 1'b0 : port_dir_rx;
	assign rx_src = serial_ctrl_a[A_LOOP] ? tx_line : rx_pin;

	// Control registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			serial_ctrl_a <= CTRL_RESET;
			baud_div <= BAUD_RESET;
		end else if (reg_write && reg_addr == ADDR_CTRL_A) begin
			serial_ctrl_a <= reg_wdata;
		end else if (reg_write && reg_addr == ADDR_BAUD) begin
			baud_div <= reg_wdata;
		end
	end

	// Enables of transmitter and receiver only change while enabled
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			serial_ctrl_b <= CTRL_RESET;
		end else begin
			if (reg_write && reg_addr == ADDR_CTRL_B) begin
				serial_ctrl_b <= reg_wdata;
				if (!en) begin
					serial_ctrl_b[B_TE] <= serial_ctrl_b[B_TE];
					serial_ctrl_b[B_RE] <= serial_ctrl_b[B_RE];
				end
			end
			if (rx_done && serial_ctrl_b[B_RWU]) begin
				if (serial_ctrl_a[A_WAKE] && rx_msb) begin
					serial_ctrl_b[B_RWU] <= 1'b0;
				end
			end
			if (idle_seen && serial_ctrl_b[B_RWU] && !serial_ctrl_a[A_WAKE]) begin
				serial_ctrl_b[B_RWU] <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			serial_ctrl_c <= CTRL_RESET;
		end else begin
			if (reg_write && reg_addr == ADDR_CTRL_C) begin
				serial_ctrl_c[6:0] <= reg_wdata[6:0];
			end
			if (rx_done && !serial_status_a.rx_full) begin
				serial_ctrl_c[C_R8] <= long_char ? rx_char[8] : rx_char[7];
			end
		end
	end

	// Two-step clears: arm by status read, finish by data access
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			arm_rx <= 1'b0;
			arm_tx <= 1'b0;
		end else if (reg_read && reg_addr == ADDR_STATUS_A && !protect) begin
			arm_rx <= |serial_status_a[5:0];
			arm_tx <= serial_status_a.tx_empty;
		end
	end
	assign clear_rx = reg_read && reg_addr == ADDR_DATA && arm_rx && !protect;
	assign clear_tx = reg_write && reg_addr == ADDR_DATA && arm_tx && !protect;

	// Status flags; a set in the same cycle wins over a clear
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			serial_status_a <= STATUS_RESET;
		end else begin
			if (clear_rx) begin
				serial_status_a.rx_full <= 1'b0;
				serial_status_a.idle <= 1'b0;
				serial_status_a.overrun <= 1'b0;
				serial_status_a.noise <= 1'b0;
				serial_status_a.framing <= 1'b0;
				serial_status_a.parity <= 1'b0;
			end
			if (clear_tx) begin
				serial_status_a.tx_empty <= 1'b0;
			end
			if (tx_load) begin
				serial_status_a.tx_empty <= 1'b1;
			end
			serial_status_a.tx_done <= serial_status_a.tx_empty && !clear_tx
				&& !tx_load && tx_state == LINE_IDLE;
			if (!en) begin
				serial_status_a.tx_empty <= 1'b1;
				serial_status_a.tx_done <= 1'b1;
			end
			if (rx_done && !(serial_ctrl_b[B_RWU]
				&& !(serial_ctrl_a[A_WAKE] && rx_msb))) begin
				if (serial_status_a.rx_full && !clear_rx) begin
					serial_status_a.overrun <= 1'b1;
				end else begin
					serial_status_a.rx_full <= 1'b1;
					serial_status_a.noise <= rx_noise || !unanimous;
					serial_status_a.framing <= !vote;
					serial_status_a.parity <= serial_ctrl_a[A_PEN]
						&& (parity_of(rx_char, long_char)
						!= serial_ctrl_a[A_PTY]);
				end
			end
			if (idle_seen && idle_armed && !serial_ctrl_b[B_RWU]) begin
				serial_status_a.idle <= 1'b1;
			end
		end
	end

	// Idle flag needs a received character since it was last cleared
	always_ff @(posedge ref_clk) begin
		if (reset || (clear_rx && serial_status_a.idle)) begin
			idle_armed <= 1'b0;
		end else if (rx_done) begin
			idle_armed <= 1'b1;
		end else if (idle_seen) begin
			idle_armed <= 1'b0;
		end
	end

	// Data register: read side holds received data, write side feeds tx
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			serial_data_reg <= 8'h00;
			tx_hold <= 8'h00;
		end else begin
			if (reg_write && reg_addr == ADDR_DATA) begin
				tx_hold <= reg_wdata;
			end
			if (rx_done && !(serial_status_a.rx_full && !clear_rx)
				&& !(serial_ctrl_b[B_RWU]
				&& !(serial_ctrl_a[A_WAKE] && rx_msb))) begin
				serial_data_reg <= rx_char[7:0];
			end
		end
	end

	// Read data one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			case (reg_addr)
				ADDR_CTRL_A: reg_rdata <= serial_ctrl_a;
				ADDR_CTRL_B: reg_rdata <= serial_ctrl_b;
				ADDR_CTRL_C: reg_rdata <= serial_ctrl_c;
				ADDR_STATUS_A: reg_rdata <= serial_status_a;
				ADDR_DATA: reg_rdata <= serial_data_reg;
				ADDR_BAUD: reg_rdata <= baud_div;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Transmitter: takes the holding byte when the empty flag is clear
	assign tx_load = run && serial_ctrl_b[B_TE] && tx_state == LINE_IDLE
		&& !serial_status_a.tx_empty && rt_tick;
	always_ff @(posedge ref_clk) begin
		if (reset || !en) begin
			tx_state <= LINE_IDLE;
			tx_rt <= 4'h0;
			tx_bit <= 4'h0;
			tx_shift <= 9'h000;
		end else if (rt_tick) begin
			tx_rt <= tx_rt + 4'h1;
			case (tx_state)
				LINE_IDLE: begin
					tx_rt <= 4'h0;
					if (tx_load) begin
						tx_state <= LINE_START;
						tx_bit <= 4'h0;
						tx_shift <= {serial_ctrl_c[C_T8], tx_hold};
						if (serial_ctrl_a[A_PEN] && long_char) begin
							tx_shift[8] <= parity_of({1'b0, tx_hold}, 1'b1)
								^ serial_ctrl_a[A_PTY];
						end else if (serial_ctrl_a[A_PEN]) begin
							tx_shift[7] <= parity_of({2'b00, tx_hold[6:0]},
								1'b0) ^ serial_ctrl_a[A_PTY];
						end
					end
				end
				LINE_START: begin
					if (tx_rt == RT_LAST) begin
						tx_state <= LINE_DATA;
					end
				end
				LINE_DATA: begin
					if (tx_rt == RT_LAST) begin
						tx_shift <= {1'b1, tx_shift[8:1]};
						tx_bit <= tx_bit + 4'h1;
						if (tx_bit == (long_char ? DATA_LONG : DATA_SHORT)
							- 4'h1) begin
							tx_state <= LINE_STOP;
						end
					end
				end
				LINE_STOP: begin
					if (tx_rt == RT_LAST) begin
						tx_state <= LINE_IDLE;
					end
				end
				default: tx_state <= LINE_IDLE;
			endcase
		end
	end
	assign tx_line = (tx_state == LINE_START) ? 1'b0
		: (tx_state == LINE_DATA) ? tx_shift[0] : 1'b1;

	// Receiver: three samples per bit, majority vote
	assign vote = (rx_samp[1] & rx_samp[0]) | (rx_src & (rx_samp[1] | rx_samp[0]));
	assign unanimous = (rx_samp[1] == rx_samp[0]) && (rx_samp[0] == rx_src);
	assign rx_done = rt_tick && rx_state == LINE_STOP && rx_rt == RT_SAMPLE_C;
	assign rx_char = rx_shift;
	assign rx_msb = long_char ? rx_shift[8] : rx_shift[7];
	always_ff @(posedge ref_clk) begin
		if (reset || !en || !serial_ctrl_b[B_RE]) begin
			rx_state <= LINE_IDLE;
			rx_rt <= 4'h0;
			rx_bit <= 4'h0;
			rx_shift <= 9'h000;
			rx_samp <= 2'b11;
			rx_noise <= 1'b0;
		end else if (rt_tick) begin
			rx_rt <= rx_rt + 4'h1;
			if (rx_rt == RT_SAMPLE_A || rx_rt == RT_SAMPLE_B) begin
				rx_samp <= {rx_samp[0], rx_src};
			end
			case (rx_state)
				LINE_IDLE: begin
					rx_rt <= 4'h1;
					rx_noise <= 1'b0;
					rx_bit <= 4'h0;
					if (!rx_src) begin
						rx_state <= LINE_START;
					end
					if (rx_src) begin
						rx_rt <= 4'h0;
					end
				end
				LINE_START: begin
					if (rx_rt == RT_SAMPLE_C) begin
						rx_noise <= !unanimous;
						if (vote) begin
							rx_state <= LINE_IDLE;
						end
					end else if (rx_rt == RT_LAST) begin
						rx_state <= LINE_DATA;
					end
				end
				LINE_DATA: begin
					if (rx_rt == RT_SAMPLE_C) begin
						rx_noise <= rx_noise || !unanimous;
						rx_shift <= long_char ? {vote, rx_shift[8:1]}
							: {1'b0, vote, rx_shift[7:1]};
						rx_bit <= rx_bit + 4'h1;
					end else if (rx_rt == RT_LAST && rx_bit ==
						(long_char ? DATA_LONG : DATA_SHORT)) begin
						rx_state <= LINE_STOP;
					end
				end
				LINE_STOP: begin
					if (rx_rt == RT_SAMPLE_C) begin
						rx_state <= LINE_IDLE;
					end
				end
				default: rx_state <= LINE_IDLE;
			endcase
		end
	end

	// Idle line: count whole bit times of 1s
	always_ff @(posedge ref_clk) begin
		if (reset || !en || !serial_ctrl_b[B_RE]) begin
			idle_cnt <= 4'h0;
		end else if (rt_tick && rx_rt == RT_SAMPLE_C) begin
			if (!vote || rx_state == LINE_START
				|| (serial_ctrl_a[A_IDLE_COUNT_START_SEL] && rx_state != LINE_IDLE)) begin
				idle_cnt <= 4'h0;
			end else if (idle_cnt != IDLE_LONG) begin
				idle_cnt <= idle_cnt + 4'h1;
			end
		end else if (rt_tick && rx_state == LINE_IDLE && rx_rt == 4'h0
			&& rx_src && idle_cnt != IDLE_LONG && rx_bit == 4'h0) begin
			idle_cnt <= idle_cnt;
		end
	end
	assign idle_seen = rt_tick && rx_rt == RT_SAMPLE_C && vote
		&& idle_cnt == (long_char ? IDLE_LONG : IDLE_SHORT) - 4'h1;

	// Interrupt requests stay up while their flags stay set, except rx in standby (RWU set) and tx while the unit is disabled
	assign err_irq = (serial_status_a.overrun && serial_ctrl_c[C_OVERRUN_IRQ_EN])
		|| (serial_status_a.noise && serial_ctrl_c[C_NOISE_IRQ_EN])
		|| (serial_status_a.framing && serial_ctrl_c[C_FRAMING_IRQ_EN])
		|| (serial_status_a.parity && serial_ctrl_c[C_PARITY_IRQ_EN]);
	assign tx_irq = en && ((serial_status_a.tx_empty && serial_ctrl_b[B_TIE])
		|| (serial_status_a.tx_done && serial_ctrl_b[B_TX_DONE_IRQ_EN]));
	assign rx_irq = !serial_ctrl_b[B_RWU]
		&& ((serial_status_a.rx_full && serial_ctrl_b[B_RIE])
		|| (serial_status_a.idle && serial_ctrl_b[B_ILIE]));
	assign cpu_wake = err_irq || tx_irq || rx_irq;

endmodule

/* File: test/sci_core_chk.sv */
// Concurrent checks on the serial transceiver ports
`timescale 1ns/1ps
module sci_core_chk
	import sci_pkg::*;
(
	// Clock and reset
	input logic ref_clk,
	input logic reset,
	// Register port
	input logic [2:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic reg_write,
	input logic reg_read,
	input logic [7:0] reg_rdata,
	// Modes
	input logic stop_mode,
	input logic debug_break,
	input logic break_clear_allow,
	// Pins
	input logic port_dir_tx,
	input logic port_dir_rx,
	input logic port_out_tx,
	input logic rx_pin,
	input logic tx_pin,
	input logic tx_pin_oe,
	input logic rx_pin_oe,
	// Requests
	input logic err_irq,
	input logic tx_irq,
	input logic rx_irq,
	input logic cpu_wake
);
	logic [7:0] ctrl_a;
	logic [7:0] ctrl_b;
	logic [7:0] ctrl_c;
	// Shadow copies of the control registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ctrl_a <= CTRL_RESET;
			ctrl_b <= CTRL_RESET;
			ctrl_c <= CTRL_RESET;
		end else if (reg_write && !stop_mode) begin
			if (reg_addr == ADDR_CTRL_A)
				ctrl_a <= reg_wdata;
			if (reg_addr == ADDR_CTRL_B)
				ctrl_b <= reg_wdata;
			if (reg_addr == ADDR_CTRL_C)
				ctrl_c <= reg_wdata;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	property p_oe_enabled;
		ctrl_a[A_EN] |-> tx_pin_oe && !rx_pin_oe;
	endproperty
	a_oe_enabled: assert property (p_oe_enabled)
		else $error("pin direction not forced while enabled");
	property p_oe_port;
		!ctrl_a[A_EN] |-> tx_pin_oe == port_dir_tx && rx_pin_oe == port_dir_rx;
	endproperty
	a_oe_port: assert property (p_oe_port)
		else $error("pin direction ignores port bits while disabled");
	property p_err_masked;
		ctrl_c[3:0] == 4'h0 |-> !err_irq;
	endproperty
	a_err_masked: assert property (p_err_masked)
		else $error("error request with all enables clear");
	property p_err_held;
		$fell(err_irq) |-> $past(reg_read && reg_addr == ADDR_DATA)
			|| $past(reg_write && reg_addr == ADDR_CTRL_C);
	endproperty
	a_err_held: assert property (p_err_held)
		else $error("error request dropped without a clear");
	property p_tx_gated;
		!(ctrl_a[A_EN] && (ctrl_b[B_TIE] || ctrl_b[B_TX_DONE_IRQ_EN])) |-> !tx_irq;
	endproperty
	a_tx_gated: assert property (p_tx_gated)
		else $error("transmit request without enable");
	property p_stop_frozen;
		stop_mode && $past(stop_mode) && !$past(reg_write)
			&& !$past(reg_read) && $stable(port_out_tx)
			|-> $stable(tx_pin) && $stable(err_irq) && $stable(rx_irq);
	endproperty
	a_stop_frozen: assert property (p_stop_frozen)
		else $error("activity while halted");
	property p_break_hold;
		debug_break && !break_clear_allow && err_irq && !reg_write |=> err_irq;
	endproperty
	a_break_hold: assert property (p_break_hold)
		else $error("status cleared during protected break");
	property p_wake;
		cpu_wake == (err_irq || tx_irq || rx_irq);
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake does not follow requests");
	property p_frame_full;
		$rose(err_irq) && ctrl_c[3:0] == 4'h2 |-> rx_irq || !ctrl_b[B_RIE];
	endproperty
	a_frame_full: assert property (p_frame_full)
		else $error("framing without receive full");
	c_err: cover property ($rose(err_irq));
	c_stop: cover property (stop_mode ##1 !stop_mode);
	c_break: cover property (debug_break && err_irq);
endmodule
bind sci_core sci_core_chk chk (.ref_clk(ref_clk), .reset(reset),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.reg_read(reg_read), .reg_rdata(reg_rdata), .stop_mode(stop_mode),
	.debug_break(debug_break), .break_clear_allow(break_clear_allow),
	.port_dir_tx(port_dir_tx), .port_dir_rx(port_dir_rx),
	.port_out_tx(port_out_tx), .rx_pin(rx_pin), .tx_pin(tx_pin),
	.tx_pin_oe(tx_pin_oe), .rx_pin_oe(rx_pin_oe), .err_irq(err_irq),
	.tx_irq(tx_irq), .rx_irq(rx_irq), .cpu_wake(cpu_wake));

/* File: test/serial_peer.sv */
// Remote serial transmitter driving the receive line
`timescale 1ns/1ps
module serial_peer (
	// Line
	input wire logic ref_clk,
	output logic line
);
	initial line = 1'b1;
	// Start, n data bits LSB first, stop; bit g gets a short glitch
	task automatic send(input logic [8:0] d, input int n, input logic stp,
		input int g);
		logic b;
		for (int i = 0; i < n + 2; i++) begin
			b = (i == 0) ? 1'b0 : (i > n) ? stp : d[i - 1];
			for (int j = 0; j < 16; j++) begin
				@(posedge ref_clk);
				line <= (i == g && (j == 7 || j == 8)) ? ~b : b;
			end
		end
		@(posedge ref_clk);
		line <= 1'b1;
	endtask
	task automatic hold(input logic v);
		@(posedge ref_clk);
		line <= v;
	endtask
endmodule

/* File: test/tb_async_serial_ctrl_errors.sv */
// Self-checking bench for the serial transceiver
`timescale 1ns/1ps
module tb_async_serial_ctrl_errors;
	import sci_pkg::*;
	logic ref_clk, reset, reg_write, reg_read, rx_pin, rd_seen, lg, pt;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, v;
	logic stop_mode, debug_break, break_clear_allow;
	logic port_dir_tx, port_dir_rx, port_out_tx;
	logic tx_pin, tx_pin_oe, rx_pin_oe, err_irq, tx_irq, rx_irq, cpu_wake;
	logic [8:0] d;
	logic [15:0] n;
	logic [15:0] notes[$];
	int fail_count = 0;
	int check_count = 0;
	int seed = 32'h4bd2;
	sci_core dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .stop_mode(stop_mode),
		.debug_break(debug_break), .break_clear_allow(break_clear_allow),
		.port_dir_tx(port_dir_tx), .port_dir_rx(port_dir_rx),
		.port_out_tx(port_out_tx), .rx_pin(rx_pin), .tx_pin(tx_pin),
		.tx_pin_oe(tx_pin_oe), .rx_pin_oe(rx_pin_oe), .err_irq(err_irq),
		.tx_irq(tx_irq), .rx_irq(rx_irq), .cpu_wake(cpu_wake));
	serial_peer peer (.ref_clk(ref_clk), .line(rx_pin));
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input logic [7:0] g, input logic [7:0] e,
		input logic [7:0] m);
		check_count++;
		if ((g & m) !== (e & m)) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk(input logic g, input logic e);
		cmp({7'h00, g}, {7'h00, e}, 8'h01);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] w);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= w;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e,
		input logic [7:0] m);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		notes.push_back({m, e});
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1;
	endtask
	task automatic cfg(input logic [7:0] a, input logic [7:0] c);
		wr(ADDR_CTRL_A, a);
		wr(ADDR_CTRL_B, 8'h2c);
		wr(ADDR_CTRL_C, c);
	endtask
	task automatic wait_rx;
		int k;
		for (k = 0; k < 1000 && rx_irq !== 1'b1; k++)
			@(posedge ref_clk);
		if (k == 1000) begin
			fail_count++;
			complete_run();
		end
	endtask
	// Read data is checked in the cycle after the strobe against the next queued note
	always @(posedge ref_clk) begin
		if (rd_seen) begin
			n = notes.pop_front();
			cmp(reg_rdata, n[7:0], n[15:8]);
		end
		rd_seen <= reg_read;
	end
	initial begin
		{reset, reg_write, reg_read, rd_seen, stop_mode} = 5'h10;
		{debug_break, break_clear_allow, reg_addr, reg_wdata} = 13'h0;
		{port_dir_tx, port_dir_rx, port_out_tx} = 3'($random(seed));
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		rd(ADDR_CTRL_A, 8'h00, 8'hff);
		rd(ADDR_CTRL_B, 8'h00, 8'hc0);
		rd(ADDR_STATUS_A, 8'hc0, 8'hff);
		rd(3'h6, 8'h00, 8'hff);
		for (int i = 0; i < 3; i++) begin
			v = 8'($random(seed)) & 8'hbf;
			wr(ADDR_CTRL_A, v);
			rd(ADDR_CTRL_A, v, 8'hff);
		end
		for (int i = 0; i < 2; i++) begin
			{port_dir_tx, port_dir_rx, port_out_tx} <= 3'($random(seed));
			wr(ADDR_CTRL_A, i[0] ? 8'h60 : 8'h40);
			chk(tx_pin_oe, 1'b1);
			chk(rx_pin_oe, 1'b0);
			chk(tx_pin, ~i[0]);
		end
		stop_mode <= 1'b1;
		repeat (20) @(posedge ref_clk);
		stop_mode <= 1'b0;
		rd(ADDR_CTRL_A, 8'h60, 8'hff);
		for (int i = 0; i < 5; i++) begin
			lg = i[1];
			pt = i[0];
			d = 9'($random(seed));
			cfg({3'h2, lg, 3'b001, pt}, 8'h01);
			if (lg)
				d[8] = ^d[7:0] ^ pt;
			else
				d[7] = ^d[6:0] ^ pt;
			if (i == 4)
				d[7] = ~d[7];
			peer.send(d, lg ? 9 : 8, 1'b1, -1);
			rd(ADDR_STATUS_A, {7'h10, i == 4}, 8'h2f);
			chk(err_irq, i == 4);
			rd(ADDR_DATA, d[7:0], lg ? 8'hff : 8'h7f);
		end
		cfg(8'h40, 8'h0d);
		peer.send(9'h0a5, 8, 1'b0, -1);
		chk(err_irq, 1'b0);
		wr(ADDR_CTRL_C, 8'h02);
		chk(err_irq, 1'b1);
		chk(rx_irq, 1'b1);
		rd(ADDR_STATUS_A, 8'h22, 8'h2f);
		rd(ADDR_DATA, 8'ha5, 8'hff);
		chk(err_irq, 1'b0);
		wr(ADDR_CTRL_C, 8'h04);
		peer.send(9'h0f0, 8, 1'b1, 3);
		chk(err_irq, 1'b1);
		rd(ADDR_STATUS_A, 8'h24, 8'h24);
		rd(ADDR_DATA, 8'h00, 8'h00);
		wr(ADDR_CTRL_C, 8'h08);
		peer.send(9'h011, 8, 1'b1, -1);
		peer.send(9'h022, 8, 1'b1, -1);
		rd(ADDR_STATUS_A, 8'h28, 8'h2f);
		chk(err_irq, 1'b1);
		debug_break <= 1'b1;
		rd(ADDR_DATA, 8'h11, 8'hff);
		rd(ADDR_STATUS_A, 8'h28, 8'h2f);
		debug_break <= 1'b0;
		rd(ADDR_DATA, 8'h11, 8'hff);
		rd(ADDR_STATUS_A, 8'h00, 8'h2f);
		peer.send(9'h033, 8, 1'b0, -1);
		{debug_break, break_clear_allow} <= 2'b11;
		rd(ADDR_STATUS_A, 8'h22, 8'h2f);
		rd(ADDR_DATA, 8'h33, 8'hff);
		{debug_break, break_clear_allow} <= 2'b00;
		rd(ADDR_STATUS_A, 8'h00, 8'h2f);
		wr(ADDR_CTRL_A, 8'hc0);
		peer.hold(1'b0);
		rd(ADDR_STATUS_A, 8'h80, 8'h80);
		wr(ADDR_DATA, 8'h5a);
		wait_rx();
		rd(ADDR_STATUS_A, 8'h20, 8'h2f);
		rd(ADDR_DATA, 8'h5a, 8'hff);
		peer.hold(1'b1);
		wr(ADDR_CTRL_B, 8'h80);
		chk(tx_irq, 1'b1);
		wr(ADDR_CTRL_B, 8'h00);
		chk(tx_irq, 1'b0);
		repeat (40) @(posedge ref_clk);
		wr(ADDR_CTRL_B, 8'h40);
		chk(tx_irq, 1'b1);
		wr(ADDR_CTRL_B, 8'hc0);
		wr(ADDR_CTRL_A, 8'h00);
		chk(tx_irq, 1'b0);
		rd(ADDR_STATUS_A, 8'hc0, 8'hc0);
		repeat (3) @(posedge ref_clk);
		complete_run();
	end
endmodule
